// >>> core/ram_self_test_control.sv
module ram_self_test_control
  import ram_self_test_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic post_reset_test_skip,
  input wire logic test_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic host_ram_wr,
  input wire logic [RAM_ADDR_W-1:0] host_ram_addr,
  input wire logic [RAM_DATA_W-1:0] host_ram_wdata,
  input wire logic [RAM_DATA_W-1:0] host_ram_protect,
  output logic ram_we,
  output logic [RAM_ADDR_W-1:0] ram_addr,
  output logic [RAM_DATA_W-1:0] ram_wdata,
  output logic [RAM_DATA_W-1:0] ram_wmask,
  input wire logic [RAM_DATA_W-1:0] ram_rdata,
  output logic ready,
  output logic bist_busy
);

  // Pin synchronisers
  logic skip_s1_r, skip_s2_r;
  logic test_s1_r, test_s2_r;

  // Engine state
  state_type state_r, state_nxt;
  op_type op_r, op_nxt;
  logic [RAM_ADDR_W-1:0] addr_r, addr_nxt;
  logic auto_r, auto_nxt; // Run belongs to the post-reset test
  logic fail_r, fail_nxt; // Sticky compare mismatch
  logic [1:0] cnt_r, cnt_nxt; // Settle and drain counter
  logic [1:0] rd_pend_r, rd_pend_nxt; // Read pipeline valid
  logic [RAM_DATA_W-1:0] exp0_r, exp0_nxt; // Expected word, stage 0
  logic [RAM_DATA_W-1:0] exp1_r, exp1_nxt; // Expected word, stage 1
  logic ready_r, ready_nxt;
  logic ram_we_r, ram_we_nxt;
  logic [RAM_ADDR_W-1:0] ram_addr_r, ram_addr_nxt;
  logic [RAM_DATA_W-1:0] ram_wdata_r, ram_wdata_nxt;
  logic [RAM_DATA_W-1:0] ram_wmask_r, ram_wmask_nxt;
  logic done_now; // Engine finishing this cycle
  logic done_fail; // Outcome of the finishing run

  // Register state
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic reg_hit; // Access aimed at the live control register
  logic start_req; // Accepted start of a host test
  logic [2:0] start_sel; // Select value written with the start

  // Expected word of a pass at a given address
  function automatic logic [RAM_DATA_W-1:0] exp_of(
    input op_type op,
    input logic [RAM_ADDR_W-1:0] a
  );
    logic [RAM_DATA_W-1:0] w;
    w = {{(RAM_DATA_W-RAM_ADDR_W){1'b0}}, a};
    case (op)
      OP_W1, OP_V1: exp_of = ONES_WORD;
      OP_WA, OP_VA: exp_of = w;
      OP_WN, OP_VN: exp_of = ~w;
      default: exp_of = ZERO_WORD;
    endcase
  endfunction : exp_of
  // Passes that compare instead of write
  function automatic logic is_verify(input op_type op);
    is_verify = (op == OP_V0) || (op == OP_V1) || (op == OP_VA) ||
                (op == OP_VN);
  endfunction : is_verify
  // Descending passes give the decrement half of inc/dec
  function automatic logic is_down(input op_type op);
    is_down = (op == OP_WN) || (op == OP_VN);
  endfunction : is_down
  // Starting address of a pass
  function automatic logic [RAM_ADDR_W-1:0] first_addr(input op_type op);
    if (op == OP_CLR) begin
      first_addr = CLEAR_FIRST;
    end else if (is_down(op)) begin
      first_addr = RAM_LAST;
    end else begin
      first_addr = RAM_FIRST;
    end
  endfunction : first_addr
  // First pass of each selected test
  function automatic op_type first_op(input logic [2:0] sel);
    case (sel)
      SEL_PATTERN, SEL_WR_ZERO: first_op = OP_W0;
      SEL_RD_ZERO: first_op = OP_V0;
      SEL_WR_ONES: first_op = OP_W1;
      SEL_RD_ONES: first_op = OP_V1;
      SEL_INC_DEC: first_op = OP_WA;
      default: first_op = OP_END;
    endcase
  endfunction : first_op
  // Pass sequencing; only the full pattern chains the fill passes
  function automatic op_type next_op(
    input op_type op,
    input logic pattern,
    input logic auto_run
  );
    case (op)
      OP_W0: next_op = pattern ? OP_V0 : OP_END;
      OP_V0: next_op = pattern ? OP_W1 : OP_END;
      OP_W1: next_op = pattern ? OP_V1 : OP_END;
      OP_V1: next_op = pattern ? OP_WA : OP_END;
      OP_WA: next_op = OP_VA;
      OP_VA: next_op = OP_WN;
      OP_WN: next_op = OP_VN;
      OP_VN: next_op = auto_run ? OP_CLR : OP_END;
      default: next_op = OP_END;
    endcase
  endfunction : next_op

  // Pins come from outside the clock domain
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      skip_s1_r <= 1'b0;
      skip_s2_r <= 1'b0;
      test_s1_r <= 1'b0;
      test_s2_r <= 1'b0;
    end else begin
      skip_s1_r <= post_reset_test_skip;
      skip_s2_r <= skip_s1_r;
      test_s1_r <= test_pin;
      test_s2_r <= test_s1_r;
    end
  end

  // Engine next state
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    auto_nxt = auto_r;
    fail_nxt = fail_r;
    cnt_nxt = cnt_r;
    ready_nxt = ready_r;
    ram_we_nxt = 1'b0;
    ram_addr_nxt = ram_addr_r;
    ram_wdata_nxt = ram_wdata_r;
    ram_wmask_nxt = ONES_WORD;
    done_now = 1'b0;
    done_fail = 1'b0;
    // Read data lands two cycles after the address is issued
    rd_pend_nxt = {rd_pend_r[0], 1'b0};
    exp0_nxt = exp0_r;
    exp1_nxt = exp0_r;
    if (rd_pend_r[1] && (ram_rdata != exp1_r)) begin
      fail_nxt = 1'b1;
    end
    case (state_r)
      ST_BOOT: begin
        // Wait until the skip pin has crossed the synchroniser
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == SYNC_SETTLE) begin
          cnt_nxt = 2'h0;
          if (skip_s2_r) begin
            state_nxt = ST_IDLE;
            ready_nxt = 1'b1;
          end else begin
            state_nxt = ST_RUN;
            op_nxt = OP_WA;
            addr_nxt = RAM_FIRST;
            auto_nxt = 1'b1;
            fail_nxt = 1'b0;
          end
        end
      end
      ST_IDLE: begin
        // Host owns the RAM port; protection unless full access is on
        ram_we_nxt = host_ram_wr;
        ram_addr_nxt = host_ram_addr;
        ram_wdata_nxt = host_ram_wdata;
        ram_wmask_nxt = ctrl_r[FULL_ACCESS_BIT] ? ONES_WORD :
                        ~host_ram_protect;
        if (start_req) begin
          op_nxt = first_op(start_sel);
          addr_nxt = first_addr(first_op(start_sel));
          auto_nxt = 1'b0;
          fail_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // One word per cycle, old contents are simply overwritten
        ram_addr_nxt = addr_r;
        if (is_verify(op_r)) begin
          rd_pend_nxt[0] = 1'b1;
          exp0_nxt = exp_of(op_r, addr_r);
        end else begin
          ram_we_nxt = 1'b1;
          ram_wdata_nxt = exp_of(op_r, addr_r);
        end
        if (addr_r == (is_down(op_r) ? RAM_FIRST : RAM_LAST)) begin
          op_nxt = next_op(op_r, ctrl_r[SEL_HI:SEL_LO] == SEL_PATTERN,
                           auto_r);
          addr_nxt = first_addr(op_nxt);
          if (op_nxt == OP_END) begin
            state_nxt = ST_DRAIN;
            cnt_nxt = 2'h0;
          end
        end else if (is_down(op_r)) begin
          addr_nxt = addr_r - 13'h0001;
        end else begin
          addr_nxt = addr_r + 13'h0001;
        end
      end
      ST_DRAIN: begin
        // Let the last reads return before judging the run
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == DRAIN_LAST) begin
          done_now = 1'b1;
          done_fail = fail_r | ctrl_r[FORCE_FAIL_BIT];
          ready_nxt = 1'b1;
          auto_nxt = 1'b0;
          cnt_nxt = 2'h0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Engine registers; ready falls with reset itself
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_BOOT;
      op_r <= OP_END;
      addr_r <= RAM_FIRST;
      auto_r <= 1'b0;
      fail_r <= 1'b0;
      cnt_r <= 2'h0;
      rd_pend_r <= 2'h0;
      exp0_r <= ZERO_WORD;
      exp1_r <= ZERO_WORD;
      ready_r <= 1'b0;
      ram_we_r <= 1'b0;
      ram_addr_r <= RAM_FIRST;
      ram_wdata_r <= ZERO_WORD;
      ram_wmask_r <= ONES_WORD;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      auto_r <= auto_nxt;
      fail_r <= fail_nxt;
      cnt_r <= cnt_nxt;
      rd_pend_r <= rd_pend_nxt;
      exp0_r <= exp0_nxt;
      exp1_r <= exp1_nxt;
      ready_r <= ready_nxt;
      ram_we_r <= ram_we_nxt;
      ram_addr_r <= ram_addr_nxt;
      ram_wdata_r <= ram_wdata_nxt;
      ram_wmask_r <= ram_wmask_nxt;
    end
  end

  // Control register next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    // The address is dead unless the test pin is high
    reg_hit = test_s2_r && (reg_addr == SELF_TEST_CONTROL_OFFSET);
    start_sel = reg_wdata[SEL_HI:SEL_LO];
    // Idle codes and a busy engine never launch a run
    start_req = reg_hit && reg_wr && reg_wdata[START_BIT] &&
                (state_r == ST_IDLE) && (start_sel != SEL_IDLE) &&
                (start_sel != SEL_IDLE_ALT);
    if (reg_hit && reg_wr) begin
      // Loopback bits 5..2 are kept as plain storage here; bits 1..0 are read-only
      ctrl_nxt = (ctrl_r & ~CTRL_RW_MASK) |
                 (reg_wdata & CTRL_RW_MASK);
    end
    if (start_req) begin
      ctrl_nxt[PASS_BIT] = 1'b0;
      ctrl_nxt[FAIL_BIT] = 1'b0;
    end
    if (done_now) begin
      // Result is written last so it beats a same-cycle write
      ctrl_nxt[START_BIT] = 1'b0;
      ctrl_nxt[PASS_BIT] = ~done_fail;
      ctrl_nxt[FAIL_BIT] = done_fail;
    end
    if (reg_rd) begin
      rdata_nxt = reg_hit ? ctrl_r : 16'h0000;
    end
  end

  // Control register flops; a full-access bit left set stays set until a register write clears it or reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  assign reg_rdata = rdata_r;
  assign ram_we = ram_we_r;
  assign ram_addr = ram_addr_r;
  assign ram_wdata = ram_wdata_r;
  assign ram_wmask = ram_wmask_r;
  assign ready = ready_r;
  assign bist_busy = (state_r != ST_IDLE);

endmodule : ram_self_test_control

// >>> core/ram_self_test_pkg.sv
package ram_self_test_pkg;

  // Register map
  localparam logic [7:0] SELF_TEST_CONTROL_OFFSET = 8'h28;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Bits 0, 1, 8 and 9 are read-only; everything else is storage
  localparam logic [15:0] CTRL_RW_MASK = 16'hfcfc;

  // Field positions in the self-test control register
  localparam int FULL_ACCESS_BIT = 15;
  localparam int FORCE_FAIL_BIT = 14;
  localparam int SEL_HI = 13;
  localparam int SEL_LO = 11;
  localparam int START_BIT = 10;
  localparam int FAIL_BIT = 9;
  localparam int PASS_BIT = 8;

  // Test select codes
  localparam logic [2:0] SEL_IDLE = 3'h0;
  localparam logic [2:0] SEL_PATTERN = 3'h1;
  localparam logic [2:0] SEL_WR_ZERO = 3'h2;
  localparam logic [2:0] SEL_RD_ZERO = 3'h3;
  localparam logic [2:0] SEL_WR_ONES = 3'h4;
  localparam logic [2:0] SEL_RD_ONES = 3'h5;
  localparam logic [2:0] SEL_INC_DEC = 3'h6;
  localparam logic [2:0] SEL_IDLE_ALT = 3'h7;

  // RAM geometry and fill words
  localparam int RAM_ADDR_W = 13;
  localparam int RAM_DATA_W = 16;
  localparam logic [12:0] RAM_FIRST = 13'h0000;
  localparam logic [12:0] RAM_LAST = 13'h1fff;
  localparam logic [12:0] CLEAR_FIRST = 13'h0052;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] ONES_WORD = 16'hffff;

  // Cycle counts: pin settling after reset, read pipeline drain
  localparam logic [1:0] SYNC_SETTLE = 2'h3;
  localparam logic [1:0] DRAIN_LAST = 2'h2;

  // Engine passes over the RAM
  typedef enum logic [3:0] {
    OP_W0 = 4'h0,
    OP_V0 = 4'h1,
    OP_W1 = 4'h2,
    OP_V1 = 4'h3,
    OP_WA = 4'h4,
    OP_VA = 4'h5,
    OP_WN = 4'h6,
    OP_VN = 4'h7,
    OP_CLR = 4'h8,
    OP_END = 4'hf
  } op_type;

  // Engine states, one-hot
  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_IDLE = 4'h2,
    ST_RUN = 4'h4,
    ST_DRAIN = 4'h8
  } state_type;

endpackage : ram_self_test_pkg

// >>> testbench/ram_self_test_control_chk.sv
module ram_self_test_control_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic test_pin,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic host_ram_wr,
  input wire logic [12:0] host_ram_addr,
  input wire logic [15:0] host_ram_protect,
  input wire logic ram_we,
  input wire logic [12:0] ram_addr,
  input wire logic [15:0] ram_wmask,
  input wire logic ready,
  input wire logic bist_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Boot: busy and not ready for four edges
  sequence boot_s;
    (bist_busy && !ready) [*4];
  endsequence
  // Host RAM write that an idle engine takes
  sequence hw_s;
    host_ram_wr && !bist_busy;
  endsequence
  chk_boot_wait: assert property ($rose(resetn) |-> boot_s)
    else $error("ready or busy wrong after reset");
  chk_ready_idle: assert property ($rose(ready) |-> !bist_busy)
    else $error("ready rose while engine busy");
  chk_ready_stays: assert property (ready |=> ready)
    else $error("ready fell without reset");
  chk_host_write: assert property (hw_s |=> ram_we
    && ram_addr == $past(host_ram_addr)) else $error("host write lost");
  chk_mask_open: assert property (hw_s |=>
    (ram_wmask | $past(host_ram_protect)) == 16'hffff)
    else $error("unprotected bit masked");
  chk_engine_mask: assert property (!host_ram_wr ##1 ram_we |->
    ram_wmask == 16'hffff) else $error("engine write masked");
  chk_we_cause: assert property (ram_we |->
    $past(host_ram_wr) || $past(bist_busy)) else $error("stray RAM write");
  chk_ctrl_dead: assert property (!test_pin [*4] ##0 reg_rd |=>
    reg_rdata == 16'h0000) else $error("register live, test pin low");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule : ram_self_test_control_chk

bind ram_self_test_control ram_self_test_control_chk u_chk (.sys_clk,
  .resetn, .test_pin, .reg_rd, .reg_rdata, .host_ram_wr, .host_ram_addr,
  .host_ram_protect, .ram_we, .ram_addr, .ram_wmask, .ready, .bist_busy);

// >>> testbench/ram_model.sv
module ram_model (
  input wire logic clk,
  input wire logic we,
  input wire logic [12:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] wmask,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [8192]; // Word storage
  // Scrambled start, so a skipped pass cannot pass by luck
  initial begin
    foreach (mem[i]) mem[i] = 16'(i * 16'h9e37 + 16'h5a);
  end
  // Synchronous RAM: one-cycle read, per-bit write
  always @(posedge clk) begin
    if (we) mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
    rdata <= mem[addr];
  end
endmodule : ram_model

// >>> testbench/ram_self_test_control_bench.sv
module ram_self_test_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ram_self_test_pkg::*;
  logic sys_clk, resetn, post_reset_test_skip, test_pin, reg_wr, reg_rd;
  logic host_ram_wr, ram_we, ready, bist_busy;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, host_ram_wdata, host_ram_protect;
  logic [15:0] ram_wdata, ram_wmask, ram_rdata, res, v, got;
  logic [12:0] host_ram_addr, ram_addr;
  logic [2:0] sel_tab [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h3}; // Run order
  int fails, check_count, n;
  ram_self_test_control u_ram_self_test_control (.sys_clk, .resetn,
    .post_reset_test_skip, .test_pin, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .host_ram_wr, .host_ram_addr, .host_ram_wdata,
    .host_ram_protect, .ram_we, .ram_addr, .ram_wdata, .ram_wmask,
    .ram_rdata, .ready, .bist_busy);
  ram_model u_ram_model (.clk(sys_clk), .we(ram_we), .addr(ram_addr),
    .wdata(ram_wdata), .wmask(ram_wmask), .rdata(ram_rdata));
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input logic [15:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  // Control writes and reads, one-cycle strobes
  task wr(input logic [15:0] d);
    reg_addr = SELF_TEST_CONTROL_OFFSET;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    // Gap cycle, so a following strobe never lands in this time step
    cyc(1);
  endtask : wr
  task rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    got = reg_rdata;
  endtask : rd
  // Bounded wait for ready or for an idle engine
  task wait_for(input int lim, input bit rdy);
    n = 0;
    while (!(rdy ? ready === 1'b1 : bist_busy === 1'b0) && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) fails++;
  endtask : wait_for
  task do_reset(input logic skip);
    resetn = 1'b0;
    post_reset_test_skip = skip;
    cyc(10);
    chk(16'(ready), 16'h0000, "ready in reset");
    resetn = 1'b1;
  endtask : do_reset
  // Words from lo up to the top that differ from w
  function int bad_words(input int lo, input logic [15:0] w);
    bad_words = 0;
    for (int a = lo; a < 8192; a++) begin
      if (u_ram_model.mem[a] !== w) bad_words++;
    end
  endfunction : bad_words
  // Control value after a finished run
  function logic [15:0] run_done(input logic [15:0] d, input bit fail);
    return d & CTRL_RW_MASK & 16'hfbff | (fail ? 16'h0200 : 16'h0100);
  endfunction : run_done
  task results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Watchdog sized above the longest expected run
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    results;
  end
  initial begin
    void'($urandom(32'h80b55ed1));
    {test_pin, reg_wr, reg_rd, host_ram_wr} = '0;
    {host_ram_addr, host_ram_wdata, host_ram_protect} = '0;
    reg_addr = SELF_TEST_CONTROL_OFFSET;
    reg_wdata = 16'h0000;
    do_reset(1'b0);
    wait_for(50000, 1'b1);
    chk(16'(n > 32768), 16'h0001, "auto test length");
    chk(16'(bad_words(CLEAR_FIRST, 0)), 16'h0000, "cleared");
    wr(16'h4000);
    rd(SELF_TEST_CONTROL_OFFSET);
    chk(got, 16'h0000, "ctrl, test pin low");
    $display("auto test done");
    test_pin = 1'b1;
    cyc(4);
    res = 16'h0100;
    rd(SELF_TEST_CONTROL_OFFSET);
    chk(got, res, "ctrl after auto test");
    // Random storage writes, select kept idle
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom) & 16'hc7ff | (i[0] ? 16'h3800 : 16'h0000);
      wr(v);
      cyc(2);
      chk(16'(bist_busy), 16'h0000, "busy, idle select");
      rd(SELF_TEST_CONTROL_OFFSET);
      chk(got, v & CTRL_RW_MASK | res, "readback");
      rd(8'h29);
      chk(got, 16'h0000, "unmapped read");
    end
    // Protected host writes, then full access
    for (int i = 0; i < 2; i++) begin
      wr(i ? 16'h8000 : 16'h0000);
      host_ram_addr = 13'($urandom);
      host_ram_wdata = 16'($urandom);
      host_ram_protect = 16'($urandom);
      host_ram_wr = 1'b1;
      cyc(1);
      host_ram_wr = 1'b0;
      chk(ram_wmask, i ? 16'hffff : ~host_ram_protect, "mask");
    end
    wr(16'h0000);
    $display("register test done");
    // Fill and verify runs; last two must fail
    for (int k = 0; k < 5; k++) begin
      v = {1'b0, k == 3, sel_tab[k], 11'h400};
      wr(v);
      cyc(1);
      chk(16'(bist_busy), 16'h0001, "busy after start");
      wait_for(9000, 1'b0);
      rd(SELF_TEST_CONTROL_OFFSET);
      chk(got, run_done(v, k > 2), "result");
      res = got & 16'h0300;
      if (!sel_tab[k][0]) chk(16'(bad_words(0, {16{sel_tab[k][2]}})),
        16'h0000, "filled");
    end
    $display("host run test done");
    wr(16'h0c00);
    cyc(100);
    chk(16'(bist_busy), 16'h0001, "pattern running");
    chk(u_ram_model.mem[16], 16'h0000, "pattern word");
    do_reset(1'b1);
    wait_for(20, 1'b1);
    chk(16'(n < 8), 16'h0001, "skip boot length");
    cyc(4);
    rd(SELF_TEST_CONTROL_OFFSET);
    chk(got, CTRL_RESET, "ctrl after reset");
    wr(16'h3400);
    cyc(100);
    chk(16'(bist_busy), 16'h0001, "inc dec running");
    chk(u_ram_model.mem[16], 16'h0010, "inc dec word");
    test_pin = 1'b0;
    $display("abort test done");
    results;
  end
endmodule : ram_self_test_control_bench
